// *** rtl/ram_access_pkg.sv ***
package ram_access_pkg;

    // ==================================================================
    // Buffer memory geometry
    localparam int RAM_AW          = 11;
    localparam int RAM_DW          = 8;
    localparam int PAGE_BYTES      = 512;
    localparam int HALF_PAGE_BYTES = 256;

    // ==================================================================
    // Register indices (byte address is four times the index)
    localparam int         AXI_AW          = 8;
    localparam logic [5:0] IDX_PTR_HIGH    = 6'h02;
    localparam logic [5:0] IDX_PTR_LOW     = 6'h03;
    localparam logic [5:0] IDX_DATA        = 6'h04;
    localparam logic [5:0] IDX_FIRST_SETUP = 6'h05;
    localparam logic [5:0] IDX_COMMAND     = 6'h06;
    localparam logic [5:0] IDX_START       = 6'h07;

    // ==================================================================
    // Field positions and codes
    localparam int         AUTOINC_BIT    = 7;
    localparam int         PTR_HIGH_BITS  = 3;
    localparam int         SLOW_ARB_BIT   = 0;
    localparam int         CMD_OFFSET_BIT = 5;
    localparam int         CMD_PAGE_LSB   = 3;
    localparam logic [2:0] CMD_CODE_TX    = 3'h3;
    localparam logic [2:0] CMD_CODE_RX    = 3'h4;

    // ==================================================================
    // Reset values and bus answers
    localparam logic [7:0]        FIRST_SETUP_RESET = 8'h00;
    localparam logic [RAM_AW-1:0] ADDRESS_RESET     = 11'h000;
    localparam logic [1:0]        RESP_OKAY         = 2'h0;
    localparam logic [1:0]        RESP_SLVERR       = 2'h2;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_WRESP = 3'b010,
        BUS_RRESP = 3'b100
    } bus_state_e;

endpackage : ram_access_pkg

// *** rtl/byte_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none

module byte_buffer
    import ram_access_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [PW:0]   FULL = (PW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [PW:0]                 count;
    } buf_s;

    buf_s q;
    buf_s next_q;
    logic push;
    logic pop;

    assign in_ready  = q.count != FULL;
    assign out_valid = q.count != '0;
    assign out_data  = q.mem[q.rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // ==================================================================
    // Next state
    always_comb begin
        next_q = q;
        if (push) begin
            next_q.mem[q.wr_ptr] = in_data;
            next_q.wr_ptr = (q.wr_ptr == LAST) ? '0 : q.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_q.rd_ptr = (q.rd_ptr == LAST) ? '0 : q.rd_ptr + 1'b1;
        end
        // Full blocks push, empty blocks pop, so count never wraps
        next_q.count = q.count + (PW + 1)'(push) - (PW + 1)'(pop);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

endmodule : byte_buffer

`default_nettype wire

// *** rtl/buffer_ram.sv ***
`timescale 1ns/1ps
`default_nettype none

module buffer_ram
    import ram_access_pkg::*;
#(
    parameter int AW = RAM_AW,
    parameter int DW = RAM_DW
) (
    input  wire logic          clk,
    input  wire logic          en,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);

    // Single port; the arbiter in front grants one access per slot
    logic [DW-1:0] mem [0:(1 << AW) - 1];

    always_ff @(posedge clk) begin
        if (en) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end

endmodule : buffer_ram

`default_nettype wire

// *** rtl/sequential_ram_access.sv ***
// Overview of operation
// R1 - Buffer reached only via pointer and data
// R2 - High byte first; low byte write loads address
// R3 - Loaded address is fetched into data port
// R4 - Auto-increment steps pointer and prefetches next
// R5 - Host reloads pointer on direction change
// R6 - Host waits one cycle before first read
// R7 - Writes held, committed later, no bus stall
// R8 - Slow arbitration grants memory every other clock
// R9 - Pointer reads return current incremented address
// R10 - Host block transfer sequence with auto-increment
// R11 - Four 512-byte pages, two-bit page field
// R12 - Offset bit five adds 256 bytes
// R13 - Start is page times 512 plus offset
// R14 - Command 0x23 starts transmit at 0x100
// R15 - Received bytes fill consecutive addresses unchecked
// R16 - Host reserves 512 bytes per receive page
// R17 - Short packets allow 256-byte pages
// R18 - Unallocated areas stay host read/write storage
// R19 - Eleven-bit address wraps, high bits ignored
`timescale 1ns/1ps
`default_nettype none

module sequential_ram_access
    import ram_access_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic [RAM_DW-1:0] rx_byte,
    input  wire logic              rx_byte_valid,
    output logic                   rx_byte_ready,
    output logic                   tx_enable_pulse,
    output logic      [RAM_AW-1:0] tx_start_address,
    output logic                   rx_enable_pulse,
    output logic      [RAM_AW-1:0] rx_start_address
);

    typedef struct packed {
        bus_state_e                 bus;
        logic                       aw_got;
        logic                       w_got;
        logic [AXI_AW-1:0]          aw_addr;
        logic [7:0]                 wdata;
        logic                       wbyte;
        logic [1:0]                 bresp;
        logic [31:0]                rdata;
        logic [1:0]                 rresp;
        logic                       autoinc;
        logic [PTR_HIGH_BITS-1:0]   ptr_high_bits;
        logic [RAM_AW-1:0]          address;
        logic [RAM_DW-1:0]          data_reg;
        logic [RAM_DW-1:0]          hold;
        logic                       fetch_pending;
        logic                       fetch_busy;
        logic                       commit_pending;
        logic [7:0]                 first_setup_register;
        logic                       arb_phase;
        logic [RAM_AW-1:0]          tx_start;
        logic [RAM_AW-1:0]          rx_start;
        logic [RAM_AW-1:0]          rx_addr;
        logic                       tx_go;
        logic                       rx_go;
    } state_s;

    state_s            q;
    state_s            next_q;
    logic              slow_arbitration_select;
    logic              slot;
    logic              wr_fire;
    logic              rd_fire;
    logic              ram_en;
    logic              ram_we;
    logic [RAM_AW-1:0] ram_addr;
    logic [RAM_DW-1:0] ram_wdata;
    logic [RAM_DW-1:0] ram_rdata;
    logic              buf_valid;
    logic [RAM_DW-1:0] buf_data;
    logic              rx_take;
    logic [1:0]        page_number;
    logic              half_page;

    // ==================================================================
    // Receive stream buffer and packet memory
    byte_buffer #(
        .WIDTH (RAM_DW),
        .DEPTH (BUF_DEPTH)
    ) u_rx_buffer (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (rx_byte_valid),
        .in_ready  (rx_byte_ready),
        .in_data   (rx_byte),
        .out_valid (buf_valid),
        .out_ready (rx_take),
        .out_data  (buf_data)
    );

    buffer_ram #(
        .AW (RAM_AW),
        .DW (RAM_DW)
    ) u_ram (
        .clk   (clk),
        .en    (ram_en),
        .we    (ram_we),
        .addr  (ram_addr),
        .wdata (ram_wdata),
        .rdata (ram_rdata)
    );

    // ==================================================================
    // Bus handshakes
    assign s_axi_awready = (q.bus == BUS_IDLE) && !q.aw_got;
    assign s_axi_wready  = (q.bus == BUS_IDLE) && !q.w_got;
    // A fully collected write executes before any new read is taken
    assign s_axi_arready = (q.bus == BUS_IDLE) && !(q.aw_got && q.w_got);
    assign s_axi_bvalid  = q.bus == BUS_WRESP;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_rvalid  = q.bus == BUS_RRESP;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign wr_fire = (q.bus == BUS_IDLE) && q.aw_got && q.w_got;
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    assign tx_enable_pulse  = q.tx_go;
    assign rx_enable_pulse  = q.rx_go;
    assign tx_start_address = q.tx_start;
    assign rx_start_address = q.rx_start;

    assign slow_arbitration_select = q.first_setup_register[SLOW_ARB_BIT];
    assign page_number = q.wdata[CMD_PAGE_LSB +: 2];
    assign half_page   = q.wdata[CMD_OFFSET_BIT];
    // Halved arbitration clock only opens a slot on alternate edges
    assign slot = !slow_arbitration_select || q.arb_phase; // [R8]

    // ==================================================================
    // Next state: memory arbitration first, host bus effects after
    always_comb begin
        next_q = q;
        next_q.tx_go = 1'b0;
        next_q.rx_go = 1'b0;
        next_q.arb_phase = !q.arb_phase;
        ram_en    = 1'b0;
        ram_we    = 1'b0;
        ram_addr  = q.address;
        ram_wdata = q.hold;
        rx_take   = 1'b0;

        if (q.fetch_busy) begin
            next_q.data_reg   = ram_rdata; // [R3]
            next_q.fetch_busy = 1'b0;
        end
        // Host traffic ranks above the receive stream; the buffer absorbs
        // the wait so no incoming byte is lost
        if (slot) begin
            if (q.commit_pending) begin
                ram_en = 1'b1; // [R7] [R18]
                ram_we = 1'b1;
                next_q.commit_pending = 1'b0;
                if (q.autoinc) begin
                    next_q.address       = q.address + 1'b1; // [R4] [R19]
                    next_q.fetch_pending = 1'b1;
                end
            end else if (q.fetch_pending) begin
                ram_en = 1'b1; // [R3]
                next_q.fetch_pending = 1'b0;
                next_q.fetch_busy    = 1'b1;
            end else if (buf_valid) begin
                ram_en    = 1'b1; // [R15]
                ram_we    = 1'b1;
                ram_addr  = q.rx_addr;
                ram_wdata = buf_data;
                rx_take   = 1'b1;
                next_q.rx_addr = q.rx_addr + 1'b1; // [R15] [R19]
            end
        end

        if (s_axi_awvalid && s_axi_awready) begin
            next_q.aw_got  = 1'b1;
            next_q.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_q.w_got = 1'b1;
            next_q.wdata = s_axi_wdata[7:0];
            next_q.wbyte = s_axi_wstrb[0];
        end

        if (wr_fire) begin
            next_q.aw_got = 1'b0;
            next_q.w_got  = 1'b0;
            next_q.bus    = BUS_WRESP;
            next_q.bresp  = RESP_OKAY;
            case (q.aw_addr[7:2])
                IDX_PTR_HIGH: begin
                    if (q.wbyte) begin
                        next_q.ptr_high_bits = q.wdata[PTR_HIGH_BITS-1:0];
                        next_q.autoinc = q.wdata[AUTOINC_BIT]; // [R10]
                    end
                end
                IDX_PTR_LOW: begin
                    if (q.wbyte) begin
                        next_q.address = {q.ptr_high_bits, q.wdata}; // [R2]
                        next_q.fetch_pending = 1'b1; // [R3]
                    end
                end
                IDX_DATA: begin
                    if (q.wbyte) begin
                        next_q.hold = q.wdata; // [R7] [R1]
                        next_q.commit_pending = 1'b1;
                        next_q.fetch_pending  = 1'b0;
                    end
                end
                IDX_FIRST_SETUP: begin
                    if (q.wbyte) begin
                        next_q.first_setup_register = q.wdata; // [R8]
                    end
                end
                IDX_COMMAND: begin
                    if (q.wbyte && q.wdata[2:0] == CMD_CODE_TX) begin
                        next_q.tx_start = RAM_AW'(page_number * PAGE_BYTES
                            + half_page * HALF_PAGE_BYTES); // [R11] [R13]
                        next_q.tx_go = 1'b1; // [R14]
                    end
                    if (q.wbyte && q.wdata[2:0] == CMD_CODE_RX) begin
                        next_q.rx_start = RAM_AW'(page_number * PAGE_BYTES
                            + half_page * HALF_PAGE_BYTES); // [R12] [R13]
                        next_q.rx_addr = next_q.rx_start;
                        next_q.rx_go   = 1'b1;
                    end
                end
                IDX_START: begin
                end
                default: begin
                    next_q.bresp = RESP_SLVERR;
                end
            endcase
        end

        if (rd_fire) begin
            next_q.bus   = BUS_RRESP;
            next_q.rresp = RESP_OKAY;
            next_q.rdata = 32'h0000_0000;
            case (s_axi_araddr[7:2])
                IDX_PTR_HIGH: begin
                    next_q.rdata[7:0] = {q.autoinc, 4'h0,
                                         q.address[10:8]}; // [R9]
                end
                IDX_PTR_LOW: begin
                    next_q.rdata[7:0] = q.address[7:0]; // [R9]
                end
                IDX_DATA: begin
                    next_q.rdata[7:0] = q.data_reg; // [R1]
                    if (q.autoinc) begin
                        next_q.address = next_q.address + 1'b1; // [R4]
                        next_q.fetch_pending = 1'b1;
                    end
                end
                IDX_FIRST_SETUP: begin
                    next_q.rdata[7:0] = q.first_setup_register;
                end
                IDX_COMMAND: begin
                end
                IDX_START: begin
                    next_q.rdata = {5'h00, q.rx_start, 5'h00, q.tx_start};
                end
                default: begin
                    next_q.rresp = RESP_SLVERR;
                end
            endcase
        end

        case (q.bus)
            BUS_IDLE: begin
            end
            BUS_WRESP: begin
                if (s_axi_bready) begin
                    next_q.bus = BUS_IDLE;
                end
            end
            BUS_RRESP: begin
                if (s_axi_rready) begin
                    next_q.bus = BUS_IDLE;
                end
            end
            default: begin
                next_q.bus = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= '0;
            q.bus <= BUS_IDLE;
            q.address <= ADDRESS_RESET;
            q.first_setup_register <= FIRST_SETUP_RESET;
        end else begin
            q <= next_q;
        end
    end

    // ==================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_write_to(logic [5:0] idx);
        wr_fire && q.wbyte && q.aw_addr[7:2] == idx;
    endsequence

    sequence s_read_of(logic [5:0] idx);
        rd_fire && s_axi_araddr[7:2] == idx;
    endsequence

    property p_ptr_load;
        s_write_to(IDX_PTR_LOW) |=>
            q.address == $past({q.ptr_high_bits, q.wdata}) && q.fetch_pending;
    endproperty
    a_ptr_load: assert property (p_ptr_load) // [R2]
        else $error("pointer low write did not load address");

    property p_fetch_capture;
        q.fetch_busy |=> q.data_reg == $past(ram_rdata);
    endproperty
    a_fetch_capture: assert property (p_fetch_capture) // [R3]
        else $error("fetched byte not placed in data port");

    property p_read_step;
        s_read_of(IDX_DATA) ##0 (q.autoinc && !q.commit_pending) |=>
            q.address == $past(q.address) + 1'b1 && q.fetch_pending;
    endproperty
    a_read_step: assert property (p_read_step) // [R4]
        else $error("auto-increment did not step after data read");

    property p_write_hold;
        s_write_to(IDX_DATA) |=>
            s_axi_bvalid && q.hold == $past(q.wdata) && q.commit_pending;
    endproperty
    a_write_hold: assert property (p_write_hold) // [R7]
        else $error("data write not held or answer delayed");

    property p_slow_gap;
        (ram_en && slow_arbitration_select) ##1 slow_arbitration_select
            |-> !ram_en;
    endproperty
    a_slow_gap: assert property (p_slow_gap) // [R8]
        else $error("memory granted on adjacent clocks in slow mode");

    property p_ptr_readback;
        s_read_of(IDX_PTR_LOW) |=> s_axi_rvalid
            && s_axi_rdata[7:0] == $past(q.address[7:0]);
    endproperty
    a_ptr_readback: assert property (p_ptr_readback) // [R9]
        else $error("pointer read did not return current address");

    property p_tx_start;
        s_write_to(IDX_COMMAND) ##0 q.wdata[2:0] == CMD_CODE_TX |=>
            tx_enable_pulse ##0 tx_start_address ==
            {$past(page_number), $past(half_page), 8'h00} ##1
            !tx_enable_pulse;
    endproperty
    a_tx_start: assert property (p_tx_start) // [R13]
        else $error("transmit start address or pulse wrong");

    property p_rx_fill;
        rx_take && !(wr_fire && q.aw_addr[7:2] == IDX_COMMAND) |=>
            q.rx_addr == $past(q.rx_addr) + 1'b1;
    endproperty
    a_rx_fill: assert property (p_rx_fill) // [R15]
        else $error("received byte address did not advance");

    property p_commit_grant;
        q.commit_pending && slot |-> ram_en && ram_we
            && ram_addr == q.address ##1 !q.commit_pending;
    endproperty
    a_commit_grant: assert property (p_commit_grant) // [R7]
        else $error("held byte not committed in its slot");

endmodule : sequential_ram_access

`default_nettype wire

// *** sim/rx_source.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==================================================================
// Receive stream source; gap drops valid for a cycle after each take
module rx_source (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        go,
    input  wire logic        gap,
    input  wire logic [15:0] count,
    input  wire logic [7:0]  first,
    output logic      [7:0]  rx_byte,
    output logic             rx_byte_valid,
    input  wire logic        rx_byte_ready,
    output logic             busy
);
    logic [15:0] left;
    logic [7:0]  v;

    assign busy = left != 16'h0;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            left          <= 16'h0;
            v             <= 8'h00;
            rx_byte       <= 8'h00;
            rx_byte_valid <= 1'b0;
        end else if (go && !busy) begin
            left          <= count;
            v             <= first;
            rx_byte       <= first;
            rx_byte_valid <= 1'b1;
        end else if (rx_byte_valid && rx_byte_ready) begin
            // Consecutive values so a lost or doubled byte shows up
            left          <= left - 16'h1;
            v             <= v + 8'h01;
            rx_byte       <= (gap || left == 16'h1) ? ~v : v + 8'h01;
            rx_byte_valid <= !gap && left != 16'h1;
        end else if (busy) begin
            rx_byte       <= v;
            rx_byte_valid <= 1'b1;
        end
    end
endmodule : rx_source

`default_nettype wire

// *** sim/sequential_ram_access_paging_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module sequential_ram_access_paging_bench
    import ram_access_pkg::*;
;
    logic              clk = 0, reset = 1, go = 0, gap = 0;
    logic [AXI_AW-1:0] awaddr = 0, araddr = 0;
    logic [31:0]       wdata = 0, rdata;
    logic              awvalid = 0, wvalid = 0, bready = 0;
    logic              arvalid = 0, rready = 0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [7:0]        rx_byte, first = 0;
    logic              rx_valid, rx_ready, busy, tx_pulse, rx_pulse;
    logic [10:0]       tx_start, rx_start;
    logic [15:0]       count = 0;
    logic [3:0]        wstrb = 4'h1;
    int                n_mismatch = 0, samples_checked = 0;
    int                n_tx = 0, n_rx = 0;

    sequential_ram_access dut (
        .clk(clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx_byte(rx_byte), .rx_byte_valid(rx_valid),
        .rx_byte_ready(rx_ready), .tx_enable_pulse(tx_pulse),
        .tx_start_address(tx_start), .rx_enable_pulse(rx_pulse),
        .rx_start_address(rx_start));

    rx_source src (
        .clk(clk), .reset(reset), .go(go), .gap(gap), .count(count),
        .first(first), .rx_byte(rx_byte), .rx_byte_valid(rx_valid),
        .rx_byte_ready(rx_ready), .busy(busy));

    initial forever #25 clk = ~clk;

    always @(posedge clk) begin
        n_tx += (tx_pulse === 1'b1);
        n_rx += (rx_pulse === 1'b1);
    end

    // ==================================================================
    // Bus tasks; handshakes are sampled at the falling edge, where the
    // value equals the one seen at the next rising edge
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", n_mismatch,
                 samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [31:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic expire;
        chk("handshake", 32'h1, 32'h0);
        conclude();
    endtask : expire

    task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                      input logic [1:0] er = RESP_OKAY);
        logic       a, w, b;
        logic [1:0] r;
        int         k;
        @(posedge clk);
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(negedge clk);
            a = awready;
            w = wready;
            b = bvalid;
            r = bresp;
            @(posedge clk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) break;
        end
        bready <= 1'b0;
        if (k == 40) expire();
        chk("bresp", {30'h0, er}, {30'h0, r});
        repeat (4) @(posedge clk);
    endtask : wr

    task automatic rchk(input logic [5:0] idx, input logic [31:0] exp,
                        input string what, input logic [1:0] er = RESP_OKAY);
        logic        a, v;
        logic [31:0] d;
        logic [1:0]  r;
        int          k;
        @(posedge clk);
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(negedge clk);
            a = arready;
            v = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (a) arvalid <= 1'b0;
            if (v) break;
        end
        rready <= 1'b0;
        if (k == 40) expire();
        chk(what, exp, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
        // Spacing lets the prefetch land before the next data read
        repeat (4) @(posedge clk);
    endtask : rchk

    task automatic setp(input logic [10:0] a, input logic ai);
        wr(IDX_PTR_HIGH, {ai, 4'h0, a[10:8]});
        wr(IDX_PTR_LOW, a[7:0]);
    endtask : setp

    // ==================================================================
    // Sequence
    initial begin
        int          i, s, k;
        logic [10:0] a, et, er;
        logic [7:0]  b;
        et = 11'h0;
        er = 11'h0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        rchk(IDX_PTR_HIGH, 32'h0, "ptr_high");
        rchk(IDX_FIRST_SETUP, {24'h0, FIRST_SETUP_RESET}, "setup");
        rchk(6'h3f, 32'h0, "unmapped", RESP_SLVERR);
        wr(6'h3f, 8'h00, RESP_SLVERR);
        for (s = 0; s < 2; s++) begin
            wr(IDX_FIRST_SETUP, 8'(s));
            rchk(IDX_FIRST_SETUP, 32'(s), "setup");
            setp(11'h7fe, 1'b1);
            for (i = 0; i < 4; i++) wr(IDX_DATA, 8'(8'h40 + i + s * 16));
            rchk(IDX_PTR_LOW, 32'h02, "ptr_low");
            rchk(IDX_PTR_HIGH, 32'h80, "ptr_high");
            setp(11'h7fe, 1'b1);
            for (i = 0; i < 4; i++) begin
                b = 8'(8'h40 + i + s * 16);
                rchk(IDX_DATA, {24'h0, b}, "data");
            end
        end
        wr(IDX_FIRST_SETUP, 8'h00);
        wr(IDX_PTR_HIGH, 8'h79);
        wr(IDX_PTR_LOW, 8'h23);
        wr(IDX_DATA, 8'h5a);
        rchk(IDX_PTR_HIGH, 32'h01, "ptr_high");
        wstrb <= 4'h0;
        wr(IDX_PTR_LOW, 8'h55);
        wstrb <= 4'h1;
        rchk(IDX_PTR_LOW, 32'h23, "ptr_low");
        setp(11'h123, 1'b0);
        for (i = 0; i < 2; i++) rchk(IDX_DATA, 32'h5a, "data");
        for (i = 0; i < 16; i++) begin
            a = 11'((i / 4) * PAGE_BYTES + ((i / 2) % 2) * HALF_PAGE_BYTES);
            if (i % 2 == 0) et = a;
            else er = a;
            wr(IDX_COMMAND, {2'b00, i[1], i[3:2],
                             i[0] ? CMD_CODE_RX : CMD_CODE_TX});
            rchk(IDX_START, {5'h0, er, 5'h0, et}, "start");
            chk("tx_start", {21'h0, et}, {21'h0, tx_start});
        end
        chk("tx_pulses", 32'd8, n_tx);
        wr(IDX_COMMAND, 8'h2c);
        chk("rx_start", 32'h300, {21'h0, rx_start});
        for (s = 0; s < 2; s++) begin
            count <= s == 0 ? 16'd258 : 16'd4;
            first <= s == 0 ? 8'h00 : 8'ha0;
            gap   <= s == 1;
            go    <= 1'b1;
            @(posedge clk);
            go    <= 1'b0;
            // A pointer read runs alongside the stream without taking a memory slot
            rchk(IDX_PTR_LOW, 32'h23, "ptr_low");
            for (k = 0; k < 2000 && busy; k++) @(posedge clk);
            if (busy) expire();
            if (s == 0) wr(IDX_COMMAND, 8'h3c);
        end
        chk("rx_pulses", 32'd10, n_rx);
        setp(11'h3fe, 1'b1);
        for (i = 0; i < 4; i++) rchk(IDX_DATA, 32'(8'(8'hfe + i)), "rx_data");
        setp(11'h700, 1'b1);
        for (i = 0; i < 4; i++) rchk(IDX_DATA, 32'(8'(8'ha0 + i)), "rx_data");
        conclude();
    end
endmodule : sequential_ram_access_paging_bench

`default_nettype wire
